// File: common/wxeu_map.vh
// Operation codes, register numbers and field layout for the wide execute unit
`ifndef WXEU_MAP_VH
`define WXEU_MAP_VH
`define WXEU_OP_W 6
`define WXEU_OP_NOP 6'h00
`define WXEU_OP_BEQL 6'h01
`define WXEU_OP_BNEL 6'h02
`define WXEU_OP_BGEL 6'h03
`define WXEU_OP_BGTL 6'h04
`define WXEU_OP_BLEL 6'h05
`define WXEU_OP_BLTL 6'h06
`define WXEU_OP_BGEZALL 6'h07
`define WXEU_OP_BLTZALL 6'h08
`define WXEU_OP_DADD 6'h09
`define WXEU_OP_DADDU 6'h0A
`define WXEU_OP_DSUB 6'h0B
`define WXEU_OP_DSUBU 6'h0C
`define WXEU_OP_DDIV 6'h0D
`define WXEU_OP_DDIVU 6'h0E
`define WXEU_OP_DMULT 6'h0F
`define WXEU_OP_DMULTU 6'h10
`define WXEU_OP_DSLL 6'h11
`define WXEU_OP_DSRL 6'h12
`define WXEU_OP_DSRA 6'h13
`define WXEU_OP_DSLLV 6'h14
`define WXEU_OP_DSRLV 6'h15
`define WXEU_OP_DSRAV 6'h16
`define WXEU_OP_WIDE_LEFT_SHIFT_PLUS32 6'h17
`define WXEU_OP_DSRL32 6'h18
`define WXEU_OP_DSRA32 6'h19
`define WXEU_OP_TEQ 6'h1A
`define WXEU_OP_TNE 6'h1B
`define WXEU_OP_TGE 6'h1C
`define WXEU_OP_TLT 6'h1D
`define WXEU_OP_ERET 6'h1E
`define WXEU_OP_LLW 6'h1F
`define WXEU_OP_LLD 6'h20
`define WXEU_OP_SCW 6'h21
`define WXEU_OP_SCD 6'h22
`define WXEU_OP_SYNC 6'h23
`define WXEU_OP_WAIT 6'h24
`define WXEU_OP_DREM 6'h25
`define WXEU_OP_DREMU 6'h26
`define WXEU_LINK_REG 5'h1F
`define WXEU_SA_W 6
`define WXEU_SA_PLUS32 6'h20
`define WXEU_IMM_W 16
`define WXEU_IMM_SIGN 15
`define WXEU_DIV_CNT_W 7
`define WXEU_DIV_STEPS 7'h40
`endif

// File: rtl/wxeu_shifter.v
// Doubleword barrel shifter: left logical, right logical, right arithmetic
`timescale 1ns/100ps
`include "wxeu_map.vh"
module wxeu_shifter #(
   parameter W = 64
) (
   // Operand and control
   input wire [W-1:0] i_src,
   input wire [`WXEU_SA_W-1:0] i_amt,
   input wire i_right,
   input wire i_arith,
   // Result
   output wire [W-1:0] o_res
);
   wire [W-1:0] left_res;
   wire [W-1:0] right_res;
   wire [W:0] right_ext;
   assign left_res = i_src << i_amt;
   // Extra top bit carries the fill value, dropped after the shift
   assign right_ext = $signed({i_arith & i_src[W-1], i_src}) >>> i_amt;
   assign right_res = right_ext[W-1:0];
   assign o_res = i_right ? right_res : left_res;
endmodule

// File: rtl/wxeu_divider.v
// Iterative 64-bit restoring divider, signed or unsigned, one bit per cycle
`timescale 1ns/100ps
`include "wxeu_map.vh"
module wxeu_divider #(
   parameter W = 64
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_rst_n,
   // Request
   input wire i_start,
   input wire i_signed,
   input wire [W-1:0] i_num,
   input wire [W-1:0] i_den,
   // Result
   output reg o_done,
   output reg o_busy,
   output reg [W-1:0] o_quot,
   output reg [W-1:0] o_rem
);
   reg [W-1:0] quo;
   reg [W:0] acc;
   reg [W-1:0] den;
   reg neg_q;
   reg neg_r;
   reg [`WXEU_DIV_CNT_W-1:0] cnt;
   wire [W+1:0] trial;
   wire [W-1:0] num_abs;
   wire [W-1:0] den_abs;
   assign num_abs = (i_signed && i_num[W-1]) ? (~i_num + 1'b1) : i_num;
   assign den_abs = (i_signed && i_den[W-1]) ? (~i_den + 1'b1) : i_den;
   assign trial = {1'b0, acc[W-1:0], quo[W-1]} - {2'b00, den};
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         quo <= {W{1'b0}};
         acc <= {(W+1){1'b0}};
         den <= {W{1'b0}};
         neg_q <= 1'b0;
         neg_r <= 1'b0;
         cnt <= {`WXEU_DIV_CNT_W{1'b0}};
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_quot <= {W{1'b0}};
         o_rem <= {W{1'b0}};
      end else begin
         o_done <= 1'b0;
         if (i_start && !o_busy) begin
            quo <= num_abs;
            acc <= {(W+1){1'b0}};
            den <= den_abs;
            neg_q <= i_signed & (i_num[W-1] ^ i_den[W-1]);
            neg_r <= i_signed & i_num[W-1];
            cnt <= `WXEU_DIV_STEPS;
            o_busy <= 1'b1;
         end else if (o_busy) begin
            if (trial[W+1]) begin
               acc <= {acc[W-1:0], quo[W-1]};
               quo <= {quo[W-2:0], 1'b0};
            end else begin
               acc <= trial[W:0];
               quo <= {quo[W-2:0], 1'b1};
            end
            cnt <= cnt - 1'b1;
            if (cnt == 1) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end
         end
         if (o_done) begin
            o_quot <= neg_q ? (~quo + 1'b1) : quo;
            o_rem <= neg_r ? (~acc[W-1:0] + 1'b1) : acc[W-1:0];
         end
      end
   end
endmodule

// File: rtl/wxeu_top.v
// Wide integer execute unit: branches, arithmetic, shifts, traps, ordering
//
// Summary of operation
// - Likely branch taken, else cancel delay slot
// - Likely link branches always write r31
// - Unsigned suffix compares unsigned, else signed
// - Signed doubleword add traps on overflow
// - Unsigned doubleword add never traps
// - Doubleword subtract; signed form traps overflow
// - Signed divide: quotient LO, remainder HI
// - Unsigned divide: quotient LO, remainder HI
// - Doubleword multiply, signed or unsigned form
// - Left shift fills low bits with zeros
// - Variable shifts use low six amount bits
// - Plus-32 shifts add thirty-two to amount
// - Arithmetic right shift replicates sign bit
// - Trap on equal or not equal
// - Trap compares signed or unsigned by form
// - Immediate trap operand is sign-extended
// - Exception return resumes normal execution
// - Linked load, conditional store imply barrier
// - Barrier holds memory ops until drained
// - Wait halts pipeline into low power
// - Remainder traps zero divisor; signed overflow
`timescale 1ns/100ps
`include "wxeu_map.vh"
module wxeu_top #(
   parameter W = 64
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_rst_n,
   // Issue
   input wire i_valid,
   input wire [`WXEU_OP_W-1:0] i_op,
   input wire i_unsigned,
   input wire i_use_imm,
   input wire [W-1:0] i_rs,
   input wire [W-1:0] i_rt,
   input wire [`WXEU_IMM_W-1:0] i_imm,
   input wire [`WXEU_SA_W-1:0] i_sa,
   input wire [4:0] i_rd,
   input wire [W-1:0] i_link_addr,
   // Pipeline status
   input wire i_mem_pending,
   input wire i_wake,
   // Issue handshake
   output reg o_ready,
   // Writeback
   output reg o_wb_en,
   output reg [4:0] o_wb_reg,
   output reg [W-1:0] o_wb_data,
   // Branch
   output reg o_br_taken,
   output reg o_br_cancel_slot,
   // Special registers
   output reg [W-1:0] o_hi,
   output reg [W-1:0] o_lo,
   // Exceptions
   output reg o_trap,
   output reg o_ovf,
   output reg o_eret,
   // Memory ordering and power
   output reg o_mem_hold,
   output reg o_ordered,
   output reg o_sleep
);
   localparam ST_RUN = 2'b00;
   localparam ST_DIV = 2'b01;
   localparam ST_SYNC = 2'b10;
   localparam ST_WAIT = 2'b11;

   reg [1:0] state;
   reg [1:0] next_state;
   reg div_is_rem;
   reg [4:0] div_rd;
   reg div_trap_pending;

   wire [W-1:0] imm_ext;
   wire [W-1:0] opb;
   wire eq;
   wire lt_s;
   wire lt_u;
   wire lt;
   wire [W-1:0] sum;
   wire [W-1:0] dif;
   wire add_ovf;
   wire sub_ovf;
   wire [W-1:0] sh_res;
   wire [`WXEU_SA_W-1:0] sh_amt;
   wire sh_right;
   wire sh_arith;
   wire [2*W-1:0] prod_s;
   wire [2*W-1:0] prod_u;
   wire div_start;
   wire div_signed;
   wire div_done;
   wire div_busy;
   wire [W-1:0] div_q;
   wire [W-1:0] div_r;
   wire is_div;
   wire is_rem;
   wire rem_zero;
   wire rem_ovf;
   wire is_mem_sync;
   wire go;

   assign go = i_valid && o_ready;
   assign imm_ext = {{(W-`WXEU_IMM_W){i_imm[`WXEU_IMM_SIGN]}}, i_imm};
   assign opb = i_use_imm ? imm_ext : i_rt;
   assign eq = (i_rs == opb);
   assign lt_s = ($signed(i_rs) < $signed(opb));
   assign lt_u = (i_rs < opb);
   assign lt = i_unsigned ? lt_u : lt_s;
   assign sum = i_rs + opb;
   assign dif = i_rs - opb;
   assign add_ovf = (i_rs[W-1] == opb[W-1]) && (sum[W-1] != i_rs[W-1]);
   assign sub_ovf = (i_rs[W-1] != opb[W-1]) && (dif[W-1] != i_rs[W-1]);
   assign prod_s = $signed(i_rs) * $signed(i_rt);
   assign prod_u = i_rs * i_rt;

   // Shift controls; plus-32 forms set the top amount bit
   assign sh_right = (i_op == `WXEU_OP_DSRL) || (i_op == `WXEU_OP_DSRA) ||
                     (i_op == `WXEU_OP_DSRLV) || (i_op == `WXEU_OP_DSRAV) ||
                     (i_op == `WXEU_OP_DSRL32) || (i_op == `WXEU_OP_DSRA32);
   assign sh_arith = (i_op == `WXEU_OP_DSRA) || (i_op == `WXEU_OP_DSRAV) ||
                     (i_op == `WXEU_OP_DSRA32);
   assign sh_amt = ((i_op == `WXEU_OP_DSLLV) || (i_op == `WXEU_OP_DSRLV) ||
                    (i_op == `WXEU_OP_DSRAV)) ? i_rs[`WXEU_SA_W-1:0] :
                   ((i_op == `WXEU_OP_WIDE_LEFT_SHIFT_PLUS32) || (i_op == `WXEU_OP_DSRL32) ||
                    (i_op == `WXEU_OP_DSRA32)) ? (i_sa | `WXEU_SA_PLUS32) :
                   i_sa;

   wxeu_shifter #(.W(W)) u_shifter (
      .i_src(i_rt),
      .i_amt(sh_amt),
      .i_right(sh_right),
      .i_arith(sh_arith),
      .o_res(sh_res)
   );

   // Divide and remainder share one iterative divider
   assign is_div = (i_op == `WXEU_OP_DDIV) || (i_op == `WXEU_OP_DDIVU);
   assign is_rem = (i_op == `WXEU_OP_DREM) || (i_op == `WXEU_OP_DREMU);
   assign rem_zero = (opb == {W{1'b0}});
   assign rem_ovf = (i_op == `WXEU_OP_DREM) && (i_rs == {1'b1, {(W-1){1'b0}}}) &&
                    (opb == {W{1'b1}});
   assign div_signed = (i_op == `WXEU_OP_DDIV) || (i_op == `WXEU_OP_DREM);
   // Remainder traps are caught before the divider is ever started
   assign div_start = go && (is_div || (is_rem && !rem_zero && !rem_ovf));

   wxeu_divider #(.W(W)) u_divider (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_start(div_start),
      .i_signed(div_signed),
      .i_num(i_rs),
      .i_den(opb),
      .o_done(div_done),
      .o_busy(div_busy),
      .o_quot(div_q),
      .o_rem(div_r)
   );

   assign is_mem_sync = (i_op == `WXEU_OP_LLW) || (i_op == `WXEU_OP_LLD) ||
                        (i_op == `WXEU_OP_SCW) || (i_op == `WXEU_OP_SCD) ||
                        (i_op == `WXEU_OP_SYNC);

   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (div_start) begin
               next_state = ST_DIV;
            end else if (go && is_mem_sync && i_mem_pending) begin
               next_state = ST_SYNC;
            end else if (go && (i_op == `WXEU_OP_WAIT)) begin
               next_state = ST_WAIT;
            end
         end
         ST_DIV: begin
            if (div_trap_pending) begin
               next_state = ST_RUN;
            end
         end
         ST_SYNC: begin
            if (!i_mem_pending) begin
               next_state = ST_RUN;
            end
         end
         ST_WAIT: begin
            if (i_wake) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_RUN;
         div_is_rem <= 1'b0;
         div_rd <= 5'h00;
         div_trap_pending <= 1'b0;
         o_ready <= 1'b1;
         o_wb_en <= 1'b0;
         o_wb_reg <= 5'h00;
         o_wb_data <= {W{1'b0}};
         o_br_taken <= 1'b0;
         o_br_cancel_slot <= 1'b0;
         o_hi <= {W{1'b0}};
         o_lo <= {W{1'b0}};
         o_trap <= 1'b0;
         o_ovf <= 1'b0;
         o_eret <= 1'b0;
         o_mem_hold <= 1'b0;
         o_ordered <= 1'b0;
         o_sleep <= 1'b0;
      end else begin
         state <= next_state;
         o_ready <= (next_state == ST_RUN);
         o_mem_hold <= (next_state == ST_SYNC);
         o_sleep <= (next_state == ST_WAIT);
         o_wb_en <= 1'b0;
         o_br_taken <= 1'b0;
         o_br_cancel_slot <= 1'b0;
         o_trap <= 1'b0;
         o_ovf <= 1'b0;
         o_eret <= 1'b0;
         o_ordered <= 1'b0;
         // Divider results settle one cycle after its done strobe, so they are taken then
         div_trap_pending <= div_done;
         if (div_trap_pending) begin
            o_lo <= div_q;
            o_hi <= div_r;
            if (div_is_rem) begin
               o_wb_en <= 1'b1;
               o_wb_reg <= div_rd;
               o_wb_data <= div_r;
            end
         end
         if (go) begin
            o_wb_reg <= i_rd;
            case (i_op)
               `WXEU_OP_BEQL, `WXEU_OP_BNEL, `WXEU_OP_BGEL,
               `WXEU_OP_BGTL, `WXEU_OP_BLEL, `WXEU_OP_BLTL: begin
                  if ((i_op == `WXEU_OP_BEQL && eq) || (i_op == `WXEU_OP_BNEL && !eq) ||
                      (i_op == `WXEU_OP_BGEL && !lt) || (i_op == `WXEU_OP_BLTL && lt) ||
                      (i_op == `WXEU_OP_BGTL && !lt && !eq) ||
                      (i_op == `WXEU_OP_BLEL && (lt || eq))) begin
                     o_br_taken <= 1'b1;
                  end else begin
                     o_br_cancel_slot <= 1'b1;
                  end
               end
               `WXEU_OP_BGEZALL, `WXEU_OP_BLTZALL: begin
                  o_wb_en <= 1'b1;
                  o_wb_reg <= `WXEU_LINK_REG;
                  o_wb_data <= i_link_addr;
                  if ((i_op == `WXEU_OP_BLTZALL) == i_rs[W-1]) begin
                     o_br_taken <= 1'b1;
                  end else begin
                     o_br_cancel_slot <= 1'b1;
                  end
               end
               `WXEU_OP_DADD, `WXEU_OP_DADDU: begin
                  // Overflow suppresses writeback and hands off to exceptions
                  if (i_op == `WXEU_OP_DADD && add_ovf) begin
                     o_ovf <= 1'b1;
                  end else begin
                     o_wb_en <= 1'b1;
                     o_wb_data <= sum;
                  end
               end
               `WXEU_OP_DSUB, `WXEU_OP_DSUBU: begin
                  if (i_op == `WXEU_OP_DSUB && sub_ovf) begin
                     o_ovf <= 1'b1;
                  end else begin
                     o_wb_en <= 1'b1;
                     o_wb_data <= dif;
                  end
               end
               `WXEU_OP_DMULT: begin
                  o_hi <= prod_s[2*W-1:W];
                  o_lo <= prod_s[W-1:0];
               end
               `WXEU_OP_DMULTU: begin
                  o_hi <= prod_u[2*W-1:W];
                  o_lo <= prod_u[W-1:0];
               end
               `WXEU_OP_DSLL, `WXEU_OP_DSRL, `WXEU_OP_DSRA, `WXEU_OP_DSLLV,
               `WXEU_OP_DSRLV, `WXEU_OP_DSRAV, `WXEU_OP_WIDE_LEFT_SHIFT_PLUS32,
               `WXEU_OP_DSRL32, `WXEU_OP_DSRA32: begin
                  o_wb_en <= 1'b1;
                  o_wb_data <= sh_res;
               end
               `WXEU_OP_TEQ: begin
                  o_trap <= eq;
               end
               `WXEU_OP_TNE: begin
                  o_trap <= !eq;
               end
               `WXEU_OP_TGE: begin
                  o_trap <= !lt;
               end
               `WXEU_OP_TLT: begin
                  o_trap <= lt;
               end
               `WXEU_OP_ERET: begin
                  o_eret <= 1'b1;
               end
               `WXEU_OP_LLW, `WXEU_OP_LLD, `WXEU_OP_SCW, `WXEU_OP_SCD: begin
                  o_ordered <= 1'b1;
               end
               `WXEU_OP_DREM, `WXEU_OP_DREMU: begin
                  o_trap <= rem_zero || rem_ovf;
               end
               default: begin
                  o_wb_en <= 1'b0;
               end
            endcase
            div_is_rem <= is_rem;
            div_rd <= i_rd;
         end
      end
   end
endmodule

// File: tb/wxeu_top_monitor.sv
// Port checker for the wide execute unit, bound to its top module
`timescale 1ns/100ps
`include "wxeu_map.vh"
module wxeu_monitor #(
   parameter W = 64
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_rst_n,
   // Issue
   input wire i_valid,
   input wire [5:0] i_op,
   input wire i_use_imm,
   input wire [W-1:0] i_rs,
   input wire [W-1:0] i_rt,
   input wire [15:0] i_imm,
   input wire i_mem_pending,
   input wire i_wake,
   // Results
   input wire o_ready,
   input wire o_wb_en,
   input wire [4:0] o_wb_reg,
   input wire [W-1:0] o_wb_data,
   input wire o_br_taken,
   input wire o_br_cancel_slot,
   input wire o_trap,
   input wire o_ovf,
   input wire o_eret,
   input wire o_mem_hold,
   input wire o_ordered,
   input wire o_sleep
);
   // Operands captured at the taking edge, since results show one cycle later
   reg tk;
   reg [5:0] op;
   reg [W-1:0] a;
   reg [W-1:0] b;
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tk <= 1'b0;
         op <= 6'h00;
         a <= {W{1'b0}};
         b <= {W{1'b0}};
      end else begin
         tk <= i_valid && o_ready;
         op <= i_op;
         a <= i_rs;
         b <= i_use_imm ? {{(W-16){i_imm[15]}}, i_imm} : i_rt;
      end
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   trap_no_wb_a: assert property (o_trap || o_ovf |-> !o_wb_en)
      else $error("writeback during trap");
   add_sum_a: assert property (tk && op == `WXEU_OP_DADDU |-> o_wb_en && !o_ovf && o_wb_data == a + b)
      else $error("unsigned add wrong");
   sub_diff_a: assert property (tk && op == `WXEU_OP_DSUBU |-> !o_ovf && o_wb_data == a - b)
      else $error("unsigned subtract wrong");
   link_reg_a: assert property (tk && (op == `WXEU_OP_BGEZALL || op == `WXEU_OP_BLTZALL)
      |-> o_wb_en && o_wb_reg == `WXEU_LINK_REG)
      else $error("link not written");
   br_one_a: assert property (tk && op >= `WXEU_OP_BEQL && op <= `WXEU_OP_BLTZALL
      |-> o_br_taken != o_br_cancel_slot)
      else $error("branch neither or both");
   beq_cmp_a: assert property (tk && op == `WXEU_OP_BEQL |-> o_br_taken == (a == b))
      else $error("equal branch wrong");
   teq_cmp_a: assert property (tk && op == `WXEU_OP_TEQ |-> o_trap == (a == b))
      else $error("equal trap wrong");
   order_pulse_a: assert property (tk && op >= `WXEU_OP_LLW && op <= `WXEU_OP_SCD |-> o_ordered)
      else $error("linked access without barrier");
   eret_pulse_a: assert property (tk && op == `WXEU_OP_ERET |-> o_eret)
      else $error("return not signalled");
   sleep_enter_a: assert property (i_valid && o_ready && i_op == `WXEU_OP_WAIT
      |=> o_sleep && !o_ready)
      else $error("wait did not halt");
   sleep_hold_a: assert property (o_sleep && !i_wake |=> o_sleep)
      else $error("left wait unwoken");
   sync_hold_a: assert property (i_valid && o_ready && i_op == `WXEU_OP_SYNC && i_mem_pending
      |=> o_mem_hold)
      else $error("barrier did not hold");
   div_busy_a: assert property (i_valid && o_ready && i_op == `WXEU_OP_DDIV
      |=> (!o_ready) [*8])
      else $error("divide accepted issue early");
endmodule
bind wxeu_top wxeu_monitor #(.W(W)) wxeu_monitor_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_valid(i_valid), .i_op(i_op), .i_use_imm(i_use_imm), .i_rs(i_rs), .i_rt(i_rt),
   .i_imm(i_imm), .i_mem_pending(i_mem_pending), .i_wake(i_wake), .o_ready(o_ready),
   .o_wb_en(o_wb_en), .o_wb_reg(o_wb_reg), .o_wb_data(o_wb_data), .o_br_taken(o_br_taken),
   .o_br_cancel_slot(o_br_cancel_slot), .o_trap(o_trap), .o_ovf(o_ovf), .o_eret(o_eret),
   .o_mem_hold(o_mem_hold), .o_ordered(o_ordered), .o_sleep(o_sleep));

// File: tb/tb.sv
// Self-checking testbench for the wide execute unit
`timescale 1ns/100ps
`include "wxeu_map.vh"
module tb;
   localparam [63:0] MX = 64'h7FFFFFFFFFFFFFFF;
   localparam [63:0] MN = 64'h8000000000000000;
   localparam [63:0] M1 = 64'hFFFFFFFFFFFFFFFF;
   localparam [63:0] LNK = 64'h0000000000400A10;
   reg i_ref_clk, i_rst_n, i_valid, i_unsigned, i_use_imm, i_mem_pending, i_wake;
   reg [5:0] i_op, i_sa;
   reg [63:0] i_rs, i_rt;
   reg [15:0] i_imm;
   wire o_ready, o_wb_en, o_br_taken, o_br_cancel_slot, o_trap, o_ovf, o_eret;
   wire o_mem_hold, o_ordered, o_sleep;
   wire [4:0] o_wb_reg;
   wire [63:0] o_wb_data, o_hi, o_lo;
   integer fails, samples_checked, j;
   wxeu_top #(.W(64)) wxeu_top_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
      .i_op(i_op), .i_unsigned(i_unsigned), .i_use_imm(i_use_imm), .i_rs(i_rs), .i_rt(i_rt),
      .i_imm(i_imm), .i_sa(i_sa), .i_rd(5'h05), .i_link_addr(LNK),
      .i_mem_pending(i_mem_pending), .i_wake(i_wake), .o_ready(o_ready), .o_wb_en(o_wb_en),
      .o_wb_reg(o_wb_reg), .o_wb_data(o_wb_data), .o_br_taken(o_br_taken),
      .o_br_cancel_slot(o_br_cancel_slot), .o_hi(o_hi), .o_lo(o_lo), .o_trap(o_trap),
      .o_ovf(o_ovf), .o_eret(o_eret), .o_mem_hold(o_mem_hold), .o_ordered(o_ordered),
      .o_sleep(o_sleep));
   task report_and_stop;
      begin
         $display("Checks %0d, mismatches %0d", samples_checked, fails);
         if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [63:0] got, input [63:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Bounded wait for the unit to accept again
   task idle;
      integer n;
      begin
         n = 0;
         while (o_ready !== 1'b1 && n < 200) begin
            @(posedge i_ref_clk);
            #1;
            n = n + 1;
         end
      end
   endtask
   // One issue; returns just after the taking edge so pulses can be sampled
   task iss(input [5:0] op, input u, input m, input [63:0] rs, input [63:0] rt,
      input [15:0] imm, input [5:0] sa);
      begin
         idle;
         @(posedge i_ref_clk);
         i_valid <= 1'b1;
         i_op <= op;
         i_unsigned <= u;
         i_use_imm <= m;
         i_rs <= rs;
         i_rt <= rt;
         i_imm <= imm;
         i_sa <= sa;
         @(posedge i_ref_clk);
         i_valid <= 1'b0;
         #1;
      end
   endtask
   task br(input [5:0] op, input u, input m, input [15:0] imm, input exp);
      begin
         iss(op, u, m, M1, 64'h1, imm, 6'h00);
         chk(o_br_taken, exp);
         chk(o_br_cancel_slot, !exp);
      end
   endtask
   task ar(input [5:0] op, input m, input [63:0] rs, input [63:0] rt, input [15:0] imm,
      input [5:0] sa, input [63:0] exp, input ov);
      begin
         iss(op, 1'b0, m, rs, rt, imm, sa);
         chk(o_ovf, ov);
         chk(o_wb_en, !ov);
         if (!ov)
            chk(o_wb_data, exp);
      end
   endtask
   task tr(input [5:0] op, input u, input m, input [63:0] rs, input [63:0] rt,
      input [15:0] imm, input exp);
      begin
         iss(op, u, m, rs, rt, imm, 6'h00);
         chk(o_trap, exp);
         chk(o_wb_en, 1'b0);
      end
   endtask
   task t_branch;
      begin
         br(`WXEU_OP_BEQL, 1'b0, 1'b0, 16'h0000, 1'b0);
         br(`WXEU_OP_BNEL, 1'b0, 1'b0, 16'h0000, 1'b1);
         br(`WXEU_OP_BGEL, 1'b0, 1'b0, 16'h0000, 1'b0);
         br(`WXEU_OP_BGEL, 1'b1, 1'b0, 16'h0000, 1'b1);
         br(`WXEU_OP_BGTL, 1'b1, 1'b0, 16'h0000, 1'b1);
         br(`WXEU_OP_BLEL, 1'b0, 1'b0, 16'h0000, 1'b1);
         br(`WXEU_OP_BLTL, 1'b1, 1'b0, 16'h0000, 1'b0);
         br(`WXEU_OP_BEQL, 1'b0, 1'b1, 16'hFFFF, 1'b1);
         br(`WXEU_OP_BGEZALL, 1'b0, 1'b0, 16'h0000, 1'b0);
         chk(o_wb_reg, 5'h1F);
         chk(o_wb_data, LNK);
         br(`WXEU_OP_BLTZALL, 1'b0, 1'b0, 16'h0000, 1'b1);
         chk(o_wb_en, 1'b1);
      end
   endtask
   task t_arith;
      begin
         ar(`WXEU_OP_DADD, 1'b0, MX, 64'h1, 16'h0, 6'h0, 64'h0, 1'b1);
         ar(`WXEU_OP_DADD, 1'b1, 64'h5, 64'h0, 16'hFFFF, 6'h0, 64'h4, 1'b0);
         chk(o_wb_reg, 5'h05);
         ar(`WXEU_OP_DADDU, 1'b0, MX, 64'h1, 16'h0, 6'h0, MN, 1'b0);
         ar(`WXEU_OP_DADDU, 1'b1, 64'h0, 64'h0, 16'h8000, 6'h0, 64'hFFFFFFFFFFFF8000, 1'b0);
         ar(`WXEU_OP_DSUB, 1'b0, MN, 64'h1, 16'h0, 6'h0, 64'h0, 1'b1);
         ar(`WXEU_OP_DSUB, 1'b0, 64'h5, 64'h7, 16'h0, 6'h0, 64'hFFFFFFFFFFFFFFFE, 1'b0);
         ar(`WXEU_OP_DSUBU, 1'b0, 64'h0, 64'h1, 16'h0, 6'h0, M1, 1'b0);
         ar(`WXEU_OP_DSLL, 1'b0, 64'h0, 64'h0123456789ABCDEF, 16'h0, 6'h04,
            64'h123456789ABCDEF0, 1'b0);
         ar(`WXEU_OP_DSLLV, 1'b0, 64'h44, 64'h0123456789ABCDEF, 16'h0, 6'h00,
            64'h123456789ABCDEF0, 1'b0);
         ar(`WXEU_OP_DSRAV, 1'b0, 64'h7F, MN, 16'h0, 6'h00, M1, 1'b0);
         ar(`WXEU_OP_DSRA32, 1'b0, 64'h0, MN, 16'h0, 6'h04, 64'hFFFFFFFFF8000000, 1'b0);
         ar(`WXEU_OP_DSRL32, 1'b0, 64'h0, MN, 16'h0, 6'h00, 64'h0000000080000000, 1'b0);
         ar(`WXEU_OP_DSRL, 1'b0, 64'h0, MN, 16'h0, 6'h04, 64'h0800000000000000, 1'b0);
         ar(`WXEU_OP_WIDE_LEFT_SHIFT_PLUS32, 1'b0, 64'h0, 64'h0123456789ABCDEF, 16'h0, 6'h04,
            64'h9ABCDEF000000000, 1'b0);
         ar(`WXEU_OP_DSRA, 1'b0, 64'h0, MN, 16'h0, 6'h04, 64'hF800000000000000, 1'b0);
         ar(`WXEU_OP_DSRLV, 1'b0, 64'hC4, MN, 16'h0, 6'h00, 64'h0800000000000000, 1'b0);
      end
   endtask
   task t_muldiv;
      integer n;
      begin
         iss(`WXEU_OP_DDIV, 1'b0, 1'b0, 64'hFFFFFFFFFFFFFFF9, 64'h2, 16'h0, 6'h0);
         idle;
         chk(o_lo, 64'hFFFFFFFFFFFFFFFD);
         chk(o_hi, M1);
         iss(`WXEU_OP_DDIVU, 1'b0, 1'b0, 64'h7, 64'h2, 16'h0, 6'h0);
         idle;
         chk(o_lo, 64'h3);
         chk(o_hi, 64'h1);
         iss(`WXEU_OP_DMULT, 1'b0, 1'b0, 64'hFFFFFFFFFFFFFFFE, 64'h3, 16'h0, 6'h0);
         chk(o_hi, M1);
         chk(o_lo, 64'hFFFFFFFFFFFFFFFA);
         iss(`WXEU_OP_DMULTU, 1'b0, 1'b0, 64'hFFFFFFFFFFFFFFFE, 64'h3, 16'h0, 6'h0);
         chk(o_hi, 64'h2);
         chk(o_lo, 64'hFFFFFFFFFFFFFFFA);
         tr(`WXEU_OP_DREM, 1'b0, 1'b0, MN, M1, 16'h0, 1'b1);
         tr(`WXEU_OP_DREM, 1'b0, 1'b0, 64'h7, 64'h0, 16'h0, 1'b1);
         tr(`WXEU_OP_DREMU, 1'b0, 1'b0, 64'h7, 64'h0, 16'h0, 1'b1);
         iss(`WXEU_OP_DREMU, 1'b0, 1'b0, 64'h7, 64'h2, 16'h0, 6'h0);
         n = 0;
         while (o_wb_en !== 1'b1 && n < 200) begin
            @(posedge i_ref_clk);
            #1;
            n = n + 1;
         end
         chk(o_wb_data, 64'h1);
      end
   endtask
   task t_trap;
      begin
         tr(`WXEU_OP_TEQ, 1'b0, 1'b0, 64'h5, 64'h5, 16'h0, 1'b1);
         tr(`WXEU_OP_TNE, 1'b0, 1'b0, 64'h5, 64'h5, 16'h0, 1'b0);
         tr(`WXEU_OP_TGE, 1'b0, 1'b0, M1, 64'h1, 16'h0, 1'b0);
         tr(`WXEU_OP_TGE, 1'b1, 1'b0, M1, 64'h1, 16'h0, 1'b1);
         tr(`WXEU_OP_TLT, 1'b0, 1'b0, M1, 64'h1, 16'h0, 1'b1);
         tr(`WXEU_OP_TLT, 1'b1, 1'b0, M1, 64'h1, 16'h0, 1'b0);
         tr(`WXEU_OP_TEQ, 1'b0, 1'b1, 64'hFFFF, 64'h0, 16'hFFFF, 1'b0);
         tr(`WXEU_OP_TEQ, 1'b0, 1'b1, M1, 64'h0, 16'hFFFF, 1'b1);
      end
   endtask
   task t_order;
      begin
         iss(`WXEU_OP_ERET, 1'b0, 1'b0, 64'h0, 64'h0, 16'h0, 6'h0);
         chk(o_eret, 1'b1);
         for (j = 0; j < 2; j = j + 1) begin
            @(posedge i_ref_clk);
            i_mem_pending <= 1'b1;
            iss(j ? `WXEU_OP_SYNC : `WXEU_OP_LLW, 1'b0, 1'b0, 64'h0, 64'h0, 16'h0, 6'h0);
            chk(o_ordered, j ? 1'b0 : 1'b1);
            repeat (3) @(posedge i_ref_clk);
            #1;
            chk(o_mem_hold, 1'b1);
            @(posedge i_ref_clk);
            i_mem_pending <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
            #1;
            chk(o_mem_hold, 1'b0);
         end
         iss(`WXEU_OP_LLD, 1'b0, 1'b0, 64'h0, 64'h0, 16'h0, 6'h0);
         chk(o_ordered, 1'b1);
         iss(`WXEU_OP_SCW, 1'b0, 1'b0, 64'h0, 64'h0, 16'h0, 6'h0);
         chk(o_ordered, 1'b1);
         iss(`WXEU_OP_SCD, 1'b0, 1'b0, 64'h0, 64'h0, 16'h0, 6'h0);
         chk(o_ordered, 1'b1);
         iss(`WXEU_OP_WAIT, 1'b0, 1'b0, 64'h0, 64'h0, 16'h0, 6'h0);
         repeat (4) @(posedge i_ref_clk);
         #1;
         chk(o_sleep, 1'b1);
         chk(o_ready, 1'b0);
         @(posedge i_ref_clk);
         i_wake <= 1'b1;
         repeat (2) @(posedge i_ref_clk);
         i_wake <= 1'b0;
         #1;
         chk(o_sleep, 1'b0);
      end
   endtask
   initial begin
      i_ref_clk = 1'b0;
      forever #4 i_ref_clk = ~i_ref_clk;
   end
   // Whole run is well under a thousand cycles, so this only cuts a hang
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      fails = fails + 1;
      report_and_stop;
   end
   initial begin
      fails = 0;
      samples_checked = 0;
      i_rst_n = 1'b0;
      i_valid = 1'b0;
      i_op = 6'h00;
      i_unsigned = 1'b0;
      i_use_imm = 1'b0;
      i_rs = 64'h0;
      i_rt = 64'h0;
      i_imm = 16'h0;
      i_sa = 6'h0;
      i_mem_pending = 1'b0;
      i_wake = 1'b0;
      repeat (16) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      t_branch;
      t_arith;
      t_muldiv;
      t_trap;
      t_order;
      report_and_stop;
   end
endmodule
